// [rtl/psnoop_pkg.sv]
// constants for the power-state i/o snooper: config offsets, trigger set
// layout, reset values, self refresh timing and sequencer states.
// assumes byte-wide config access and 16-bit i/o cycle snooping.
`default_nettype none

package psnoop_pkg;

  // config window holding the four trigger sets
  localparam logic [7:0] PM_WIN_LO = 8'hD8;
  localparam logic [7:0] PM_WIN_HI = 8'hF7;

  // set index order: quick start, deep sleep, suspend to ram, power on susp
  localparam int NUM_SETS = 4;
  localparam int SET_QS = 0;
  localparam int SET_DS = 1;
  localparam int SET_SR = 2;
  localparam int SET_POS = 3;
  localparam logic [3:0][7:0] SET_BASE = {8'hD8, 8'hF0, 8'hE8, 8'hE0};
  localparam logic [7:0] SET_LAST_OFS = 8'h06;

  // byte layout inside one trigger set
  localparam logic [2:0] OFS_LOC_LO = 3'h0;
  localparam logic [2:0] OFS_LOC_HI = 3'h1;
  localparam logic [2:0] OFS_SEL_LO = 3'h2;
  localparam logic [2:0] OFS_SEL_HI = 3'h3;
  localparam logic [2:0] OFS_CMP_LO = 3'h4;
  localparam logic [2:0] OFS_CMP_HI = 3'h5;
  localparam logic [2:0] OFS_ACC = 3'h6;

  // access type encoding
  localparam int ACC_READ_BIT = 0;
  localparam int ACC_WRITE_BIT = 1;
  localparam logic [7:0] ACC_OFF = 8'h00;
  localparam logic [7:0] ACC_READ = 8'h01;
  localparam logic [7:0] ACC_WRITE = 8'h02;

  // reset values
  localparam logic [15:0] LOC_RST = 16'h0000;
  localparam logic [15:0] SEL_RST = 16'h0000;
  localparam logic [15:0] CMP_RST = 16'h0000;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] SLEEP_RST = 8'h00;
  localparam logic [7:0] ATTR_RST = 8'h00;

  // power control config register and the i/o sleep control port
  localparam logic [7:0] CTRL_CFG_ADDR = 8'h7A;
  localparam int UNLOCK_BIT = 6;
  localparam logic [15:0] SLEEP_PORT_ADDR = 16'h0022;
  localparam int ARBITER_DISABLE_BIT_BIT = 0;

  // memory attribute registers
  localparam logic [7:0] ATTR_BASE = 8'h59;
  localparam logic [7:0] ATTR_LAST = 8'h5F;
  localparam int ATTR_COUNT = 7;

  // self refresh settle time around the clock stop
  localparam int CLK_PERIOD_NS = 100;
  localparam int SR_SETTLE_NS = 300;
  localparam int SR_SETTLE_CYC_I =
    (SR_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] SR_SETTLE_CYC = 4'(SR_SETTLE_CYC_I);

  typedef enum logic [3:0] {
    SR_RUN = 4'b0001,
    SR_ENTER = 4'b0010,
    SR_HOLD = 4'b0100,
    SR_EXIT = 4'b1000
  } sr_state_t;

endpackage : psnoop_pkg

`default_nettype wire

// [rtl/trigger_match.sv]
// one snooper: port, masked data and access type compare on an i/o cycle.
// assumes the cycle fields are stable while io_valid is high.
`default_nettype none

module trigger_match (
  input wire logic [15:0] port_location, // programmed port
  input wire logic [15:0] data_select, // bits taking part in compare
  input wire logic [15:0] compare_value, // expected data
  input wire logic [7:0] access_type, // read/write enables
  input wire logic io_valid, // cycle present
  input wire logic io_write, // 1 write, 0 read
  input wire logic [15:0] io_addr, // cycle port
  input wire logic [15:0] io_data, // cycle data
  output logic hit // combinational match
);

  wire addr_ok;
  wire data_ok;
  wire type_ok;

  assign addr_ok = (io_addr == port_location);
  assign data_ok =
    ((io_data ^ compare_value) & data_select) == 16'h0000;
  // zero disables; 01h reads only, 02h writes only, 03h both
  assign type_ok = io_write ?
    access_type[psnoop_pkg::ACC_WRITE_BIT] :
    access_type[psnoop_pkg::ACC_READ_BIT];
  assign hit = io_valid & addr_ok & data_ok & type_ok;

endmodule : trigger_match

`default_nettype wire

// [rtl/power_state_io_snooper.sv]
// power-state i/o snooper: four trigger sets in config space, the i/o
// sleep control port, memory attribute registers and self refresh entry.
// assumes io_valid marks each snooped cycle for exactly one clock and that
// config accesses are byte wide, one per clock at most.
`default_nettype none

module power_state_io_snooper (
  input wire logic clk, // 10 mhz host clock
  input wire logic rst, // async reset, active high
  input wire logic cfg_wr, // config byte write strobe
  input wire logic cfg_rd, // config byte read strobe
  input wire logic [7:0] cfg_addr, // config byte offset
  input wire logic [7:0] cfg_wdata, // config write data
  output logic [7:0] cfg_rdata, // config read data
  output logic cfg_ack, // config access done pulse
  input wire logic io_valid, // snooped i/o cycle present
  input wire logic io_write, // 1 write, 0 read
  input wire logic [15:0] io_addr, // i/o port
  input wire logic [15:0] io_data, // i/o write data / read data
  output logic [7:0] io_rdata, // sleep port read data
  output logic io_claim, // sleep port read answered
  output logic prep_quick_start, // quick start pulse
  output logic prep_deep_sleep, // deep sleep pulse
  output logic prep_suspend_ram, // suspend to ram pulse
  output logic prep_power_on_suspend, // power on suspend pulse
  output logic arbiter_disable, // stop pci arbitration
  input wire logic sdram_wake, // async resume request
  output logic sdram_self_refresh, // sdram held in self refresh
  output logic sdram_clk_en // sdram clock running
);

  // ---- config decode ----
  logic [psnoop_pkg::NUM_SETS-1:0] set_hit;
  logic [psnoop_pkg::NUM_SETS-1:0][7:0] set_rd;
  logic [psnoop_pkg::NUM_SETS-1:0] snoop_hit;
  logic [7:0] power_control_config;
  logic [7:0] sleep_control_port;
  logic [7:0] memattr [psnoop_pkg::ATTR_COUNT];
  logic [3:0] prep;

  wire in_window;
  wire in_attr;
  wire in_ctrl;
  wire [7:0] attr_diff;
  wire [2:0] attr_idx;
  wire [7:0] set_rd_any;
  wire [7:0] next_cfg_rdata;
  wire unlocked;
  wire sleep_hit;
  wire sleep_wr;
  wire sleep_rd;
  wire str_clear;

  assign in_window = (cfg_addr >= psnoop_pkg::PM_WIN_LO) &&
                     (cfg_addr <= psnoop_pkg::PM_WIN_HI);
  assign in_attr = (cfg_addr >= psnoop_pkg::ATTR_BASE) &&
                   (cfg_addr <= psnoop_pkg::ATTR_LAST);
  assign in_ctrl = (cfg_addr == psnoop_pkg::CTRL_CFG_ADDR);
  assign attr_diff = cfg_addr - psnoop_pkg::ATTR_BASE;
  assign attr_idx = attr_diff[2:0];
  assign set_rd_any = set_rd[0] | set_rd[1] | set_rd[2] | set_rd[3];
  // unmapped offsets and the gap bytes of the window read as zero
  assign next_cfg_rdata = in_ctrl ? power_control_config :
                          in_attr ? memattr[attr_idx] :
                          in_window ? set_rd_any : 8'h00;

  // ---- trigger sets ----
  genvar k;
  generate
    for (k = 0; k < psnoop_pkg::NUM_SETS; k++) begin : g_set
      logic [15:0] loc;
      logic [15:0] sel;
      logic [15:0] cmp;
      logic [7:0] acc;
      wire [7:0] diff;
      wire [2:0] ofs;

      assign diff = cfg_addr - psnoop_pkg::SET_BASE[k];
      assign ofs = diff[2:0];
      assign set_hit[k] = (cfg_addr >= psnoop_pkg::SET_BASE[k]) &&
                          (diff <= psnoop_pkg::SET_LAST_OFS);
      assign set_rd[k] = !set_hit[k] ? 8'h00 :
        (ofs == psnoop_pkg::OFS_LOC_LO) ? loc[7:0] :
        (ofs == psnoop_pkg::OFS_LOC_HI) ? loc[15:8] :
        (ofs == psnoop_pkg::OFS_SEL_LO) ? sel[7:0] :
        (ofs == psnoop_pkg::OFS_SEL_HI) ? sel[15:8] :
        (ofs == psnoop_pkg::OFS_CMP_LO) ? cmp[7:0] :
        (ofs == psnoop_pkg::OFS_CMP_HI) ? cmp[15:8] : acc;

      // only rst clears these; sleep states leave them alone
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          loc <= psnoop_pkg::LOC_RST;
          sel <= psnoop_pkg::SEL_RST;
          cmp <= psnoop_pkg::CMP_RST;
          acc <= psnoop_pkg::ACC_RST;
        end else if (cfg_wr && set_hit[k]) begin
          unique case (ofs)
            psnoop_pkg::OFS_LOC_LO: loc[7:0] <= cfg_wdata;
            psnoop_pkg::OFS_LOC_HI: loc[15:8] <= cfg_wdata;
            psnoop_pkg::OFS_SEL_LO: sel[7:0] <= cfg_wdata;
            psnoop_pkg::OFS_SEL_HI: sel[15:8] <= cfg_wdata;
            psnoop_pkg::OFS_CMP_LO: cmp[7:0] <= cfg_wdata;
            psnoop_pkg::OFS_CMP_HI: cmp[15:8] <= cfg_wdata;
            default: acc <= cfg_wdata;
          endcase
        end
      end

      trigger_match u_match (
        .port_location(loc),
        .data_select(sel),
        .compare_value(cmp),
        .access_type(acc),
        .io_valid(io_valid),
        .io_write(io_write),
        .io_addr(io_addr),
        .io_data(io_data),
        .hit(snoop_hit[k])
      );
    end
  endgenerate

  // ---- config access answer ----
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_rdata <= 8'h00;
      cfg_ack <= 1'b0;
    end else begin
      cfg_rdata <= cfg_rd ? next_cfg_rdata : 8'h00;
      cfg_ack <= cfg_rd | cfg_wr;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      power_control_config <= psnoop_pkg::CTRL_RST;
    end else if (cfg_wr && in_ctrl) begin
      power_control_config <= cfg_wdata;
    end
  end

  // ---- sleep control port at i/o 22h ----
  assign unlocked = power_control_config[psnoop_pkg::UNLOCK_BIT];
  assign sleep_hit = io_valid && unlocked &&
                     (io_addr == psnoop_pkg::SLEEP_PORT_ADDR);
  assign sleep_wr = sleep_hit && io_write;
  assign sleep_rd = sleep_hit && !io_write;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sleep_control_port <= psnoop_pkg::SLEEP_RST;
    end else if (sleep_wr) begin
      sleep_control_port <= io_data[7:0];
    end
  end

  assign arbiter_disable =
    sleep_control_port[psnoop_pkg::ARBITER_DISABLE_BIT_BIT];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      io_rdata <= 8'h00;
      io_claim <= 1'b0;
    end else begin
      io_rdata <= sleep_rd ? sleep_control_port : 8'h00;
      io_claim <= sleep_rd;
    end
  end

  // ---- transition pulses ----
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prep <= 4'h0;
    end else begin
      prep <= snoop_hit;
    end
  end

  assign prep_quick_start = prep[psnoop_pkg::SET_QS];
  assign prep_deep_sleep = prep[psnoop_pkg::SET_DS];
  assign prep_suspend_ram = prep[psnoop_pkg::SET_SR];
  assign prep_power_on_suspend = prep[psnoop_pkg::SET_POS];

  // ---- memory attribute registers ----
  // the suspend clear beats a config write in the same cycle
  assign str_clear = snoop_hit[psnoop_pkg::SET_SR];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < psnoop_pkg::ATTR_COUNT; i++) begin
        memattr[i] <= psnoop_pkg::ATTR_RST;
      end
    end else if (str_clear) begin
      for (int i = 0; i < psnoop_pkg::ATTR_COUNT; i++) begin
        memattr[i] <= psnoop_pkg::ATTR_RST;
      end
    end else if (cfg_wr && in_attr) begin
      memattr[attr_idx] <= cfg_wdata;
    end
  end

  // ---- wake synchroniser ----
  logic [2:0] wake_s;
  logic wake;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wake_s <= 3'h0;
      wake <= 1'b0;
    end else begin
      wake_s <= {wake_s[1:0], sdram_wake};
      if (wake_s[1] == wake_s[2]) begin
        wake <= wake_s[2];
      end
    end
  end

  // ---- self refresh sequencer ----
  psnoop_pkg::sr_state_t sr_state;
  logic [3:0] sr_cnt;
  wire deep_req;
  wire settle_done;

  // deeper than quick start: clocks may be stopped
  assign deep_req = prep_deep_sleep | prep_suspend_ram |
                    prep_power_on_suspend;
  assign settle_done = (sr_cnt == psnoop_pkg::SR_SETTLE_CYC - 4'h1);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sr_state <= psnoop_pkg::SR_RUN;
      sr_cnt <= 4'h0;
      sdram_self_refresh <= 1'b0;
      sdram_clk_en <= 1'b1;
    end else begin
      unique case (sr_state)
        psnoop_pkg::SR_RUN: begin
          sr_cnt <= 4'h0;
          if (deep_req) begin
            sr_state <= psnoop_pkg::SR_ENTER;
            sdram_self_refresh <= 1'b1;
          end
        end
        psnoop_pkg::SR_ENTER: begin
          sr_cnt <= sr_cnt + 4'h1;
          if (settle_done) begin
            sr_state <= psnoop_pkg::SR_HOLD;
            sdram_clk_en <= 1'b0;
            sr_cnt <= 4'h0;
          end
        end
        psnoop_pkg::SR_HOLD: begin
          if (wake) begin
            sr_state <= psnoop_pkg::SR_EXIT;
            sdram_clk_en <= 1'b1;
          end
        end
        psnoop_pkg::SR_EXIT: begin
          sr_cnt <= sr_cnt + 4'h1;
          if (settle_done) begin
            sr_state <= psnoop_pkg::SR_RUN;
            sdram_self_refresh <= 1'b0;
            sr_cnt <= 4'h0;
          end
        end
      endcase
    end
  end

  // ---- checks ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_settle;
    sdram_self_refresh && sdram_clk_en [*3];
  endsequence

  sequence s_deep_start;
    prep_deep_sleep && sr_state == psnoop_pkg::SR_RUN;
  endsequence

  // a second matching cycle right behind may lawfully extend the pulse
  a_pulse_single: assert property (
    prep_quick_start && !io_valid |=> !prep_quick_start
  ) else $error("quick start pulse longer than one cycle");

  a_qs_port_cause: assert property (
    prep_quick_start |->
      $past(io_valid) && $past(io_addr) == $past(g_set[0].loc)
  ) else $error("quick start pulse without port match");

  a_masked_data: assert property (
    prep_suspend_ram |->
      (($past(io_data) ^ $past(g_set[2].cmp)) & $past(g_set[2].sel))
        == 16'h0000
  ) else $error("suspend pulse with selected data mismatch");

  a_disabled_quiet: assert property (
    (g_set[1].acc == psnoop_pkg::ACC_OFF) |=> !prep_deep_sleep
  ) else $error("disabled deep sleep set produced a pulse");

  a_read_only: assert property (
    (g_set[0].acc == psnoop_pkg::ACC_READ && io_write) |=>
      !prep_quick_start
  ) else $error("read-only set fired on a write");

  a_write_only: assert property (
    (g_set[3].acc == psnoop_pkg::ACC_WRITE && !io_write) |=>
      !prep_power_on_suspend
  ) else $error("write-only set fired on a read");

  a_port_locked: assert property (
    (io_valid && io_write && !unlocked &&
     io_addr == psnoop_pkg::SLEEP_PORT_ADDR) |=>
      $stable(sleep_control_port)
  ) else $error("sleep port written while locked");

  a_arb_follow: assert property (
    (sleep_wr && io_data[0]) |=> arbiter_disable
  ) else $error("arbiter not disabled after port write");

  a_attr_cleared: assert property (
    prep_suspend_ram |-> memattr[0] == 8'h00 && memattr[6] == 8'h00
  ) else $error("attribute registers kept on suspend");

  a_refresh_order: assert property (
    s_deep_start |=> s_settle ##1 (!sdram_clk_en && sdram_self_refresh)
  ) else $error("sdram clock stopped out of order");

  a_clk_off_refresh: assert property (
    !sdram_clk_en |-> sdram_self_refresh
  ) else $error("sdram clock off without self refresh");

endmodule : power_state_io_snooper

`default_nettype wire

// [tb/io_host_model.sv]
// host side model: issues snooped i/o cycles toward the southbridge ports.
// assumes the bench calls io_cycle from one process at a time.
`default_nettype none

module io_host_model (
  input wire logic clk, // host clock
  output logic io_valid, // cycle present
  output logic io_write, // 1 write, 0 read
  output logic [15:0] io_addr, // port
  output logic [15:0] io_data // cycle data
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    io_valid = 1'b0;
    io_write = 1'b0;
    io_addr = 16'h0000;
    io_data = 16'h0000;
  end

  // one cycle, launched after a falling edge, held across one rising edge
  task automatic io_cycle(input logic wr, input logic [15:0] a,
                          input logic [15:0] d);
    @(negedge clk);
    io_valid = 1'b1;
    io_write = wr;
    io_addr = a;
    io_data = d;
    @(posedge clk);
    @(negedge clk);
    io_valid = 1'b0;
    // released lines must not keep showing the last cycle
    io_write = ~wr;
    io_addr = ~a;
    io_data = ~d;
  endtask : io_cycle
endmodule : io_host_model

`default_nettype wire

// [tb/power_state_io_snooper_tb.sv]
// self-checking bench for the power-state i/o snooper.
// assumes config answers one cycle after the strobe and prep pulses one
// cycle after a matching snooped cycle.
`default_nettype none

module power_state_io_snooper_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk, rst, cfg_wr, cfg_rd, cfg_ack, sdram_wake;
  logic [7:0] cfg_addr, cfg_wdata, cfg_rdata, io_rdata;
  logic io_valid, io_write, io_claim, arbiter_disable;
  logic [15:0] io_addr, io_data;
  logic p_qs, p_ds, p_sr, p_pos, sdram_self_refresh, sdram_clk_en;
  logic [3:0] prep;
  int errors, samples_checked, cycles;
  logic [7:0] acc_tab [4];
  logic [3:0] rd_fire [4];
  logic [3:0] wr_fire [4];

  assign prep = {p_pos, p_sr, p_ds, p_qs};

  power_state_io_snooper dut_u (
    .clk(clk), .rst(rst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_ack(cfg_ack), .io_valid(io_valid), .io_write(io_write),
    .io_addr(io_addr), .io_data(io_data), .io_rdata(io_rdata),
    .io_claim(io_claim), .prep_quick_start(p_qs),
    .prep_deep_sleep(p_ds), .prep_suspend_ram(p_sr),
    .prep_power_on_suspend(p_pos), .arbiter_disable(arbiter_disable),
    .sdram_wake(sdram_wake), .sdram_self_refresh(sdram_self_refresh),
    .sdram_clk_en(sdram_clk_en)
  );

  io_host_model host_u (
    .clk(clk), .io_valid(io_valid), .io_write(io_write),
    .io_addr(io_addr), .io_data(io_data)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic end_sim;
    if (errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk4(input logic [3:0] got, input logic [3:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: flags %b expected %b", $time, got, exp);
    end
  endtask : chk4

  task automatic cfg_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    @(posedge clk);
    @(negedge clk);
    cfg_wr = 1'b0;
    cfg_addr = ~a;
    cfg_wdata = ~d;
    chk4({3'b000, cfg_ack}, 4'h1);
  endtask : cfg_write

  task automatic cfg_check(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    cfg_rd = 1'b1;
    cfg_addr = a;
    @(posedge clk);
    @(negedge clk);
    cfg_rd = 1'b0;
    cfg_addr = ~a;
    chk4({3'b000, cfg_ack}, 4'h1);
    chk8(cfg_rdata, exp);
  endtask : cfg_check

  // program a whole trigger set, optionally reading every byte back
  task automatic prog(input int s, input logic [15:0] loc, sel, cmp,
                      input logic [7:0] acc, input bit verify);
    logic [7:0] b [7];
    logic [7:0] base;
    base = psnoop_pkg::SET_BASE[s];
    b = '{loc[7:0], loc[15:8], sel[7:0], sel[15:8], cmp[7:0], cmp[15:8],
          acc};
    for (int k = 0; k < 7; k++) cfg_write(base + 8'(k), b[k]);
    if (verify) begin
      for (int k = 0; k < 7; k++) cfg_check(base + 8'(k), b[k]);
    end
  endtask : prog

  task automatic io_expect(input logic wr, input logic [15:0] a, d,
                           input logic [3:0] exp);
    host_u.io_cycle(wr, a, d);
    chk4(prep, exp);
  endtask : io_expect

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("Error at %0t: run did not finish in time", $time);
      end_sim();
    end
  end

  initial begin
    rst = 1'b1;
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_addr = 8'h00;
    cfg_wdata = 8'h00;
    sdram_wake = 1'b0;
    acc_tab = '{8'h01, 8'h02, 8'h03, 8'h00};
    rd_fire = '{4'h1, 4'h0, 4'h1, 4'h0};
    wr_fire = '{4'h0, 4'h1, 4'h1, 4'h0};
    repeat (5) @(negedge clk);
    rst = 1'b0;
    chk4({2'b00, sdram_self_refresh, sdram_clk_en}, 4'h1);
    for (int s = 0; s < 4; s++) begin
      for (int k = 0; k < 7; k++) begin
        cfg_check(psnoop_pkg::SET_BASE[s] + 8'(k), 8'h00);
      end
    end
    // gap byte inside the window and an unmapped offset
    cfg_write(8'hDF, 8'hFF);
    cfg_check(8'hDF, 8'h00);
    cfg_write(8'h80, 8'h5A);
    cfg_check(8'h80, 8'h00);
    // sleep control port stays hidden until unlocked
    io_expect(1'b1, 16'h0022, 16'h0001, 4'h0);
    host_u.io_cycle(1'b0, 16'h0022, 16'h0000);
    chk4({2'b00, io_claim, arbiter_disable}, 4'h0);
    cfg_write(8'h7A, 8'h40);
    cfg_check(8'h7A, 8'h40);
    host_u.io_cycle(1'b1, 16'h0022, 16'hFF01);
    chk4({3'b000, arbiter_disable}, 4'h1);
    host_u.io_cycle(1'b0, 16'h0022, 16'h0000);
    chk4({2'b00, io_claim, arbiter_disable}, 4'h3);
    chk8(io_rdata, 8'h01);
    // each set at its own offsets fires only its own pulse
    for (int s = 0; s < 4; s++) begin
      prog(s, {8'h12, 8'(s)}, 16'h0000, 16'h0000, 8'h01, 1'b1);
    end
    for (int s = 0; s < 4; s++) begin
      io_expect(1'b0, {8'h12, 8'(s)}, 16'hFFFF, 4'(1 << s));
    end
    // deep sleep pulse has put the sdram into self refresh
    chk4({2'b00, sdram_self_refresh, sdram_clk_en}, 4'h2);
    sdram_wake = 1'b1;
    for (int i = 0; i < 20 && sdram_clk_en !== 1'b1; i++) @(negedge clk);
    chk4({2'b00, sdram_self_refresh, sdram_clk_en}, 4'h3);
    repeat (5) @(negedge clk);
    chk4({2'b00, sdram_self_refresh, sdram_clk_en}, 4'h1);
    sdram_wake = 1'b0;
    repeat (6) @(negedge clk);
    // access type table on the quick start set
    prog(0, 16'h00B2, 16'h0000, 16'h0000, 8'h01, 1'b0);
    for (int i = 0; i < 4; i++) begin
      cfg_write(8'hE6, acc_tab[i]);
      io_expect(1'b0, 16'h00B2, 16'h1234, rd_fire[i]);
      io_expect(1'b1, 16'h00B2, 16'h1234, wr_fire[i]);
      io_expect(1'b1, 16'h00B3, 16'h1234, 4'h0);
    end
    // masked data compare on suspend to ram
    cfg_write(psnoop_pkg::ATTR_BASE, 8'hAA);
    cfg_check(psnoop_pkg::ATTR_BASE, 8'hAA);
    prog(2, 16'h4004, 16'h3C00, 16'h2400, 8'h02, 1'b0);
    io_expect(1'b0, 16'h4004, 16'h2400, 4'h0);
    io_expect(1'b1, 16'h4004, 16'h2800, 4'h0);
    io_expect(1'b1, 16'h4004, 16'hE7FF, 4'h4);
    for (int k = 0; k < 7; k++) begin
      cfg_check(psnoop_pkg::ATTR_BASE + 8'(k), 8'h00);
    end
    cfg_check(8'hF3, 8'h3C);
    cfg_check(8'h7A, 8'h40);
    chk4({3'b000, arbiter_disable}, 4'h1);
    // write-only power on suspend set on the same port, other pattern
    prog(3, 16'h4004, 16'h3C00, 16'h3000, 8'h02, 1'b0);
    io_expect(1'b0, 16'h4004, 16'h3000, 4'h0);
    io_expect(1'b1, 16'h4004, 16'h3000, 4'h8);
    end_sim();
  end
endmodule : power_state_io_snooper_tb

`default_nettype wire
